/* include/aio_pkg.sv */
// Behaviour
// - Register select high picks result register, low config register.
// - Before a read, serial out stays high until a new result, then low.
// - Three channel-select lines pick exactly one of eight inputs.
// - Eight independent channels, each giving a 24-bit result.
// - Bipolar, gain one: top all ones, bottom all zeros, zero mid-code.
// - Gain 1 to 128 in powers of two divides the input range.
// - Recommended setup gives 250 results per second on the chosen channel.
// - Four converter output channels of 14 bits each.
// - Each relay is on only while its line is driven low.
// - Mode line driven high selects RS485, otherwise RS232.
// - In RS485 mode the direction line high transmits, low receives.
// - Each of eight LEDs lights only while its line is driven low.
package aio_pkg;
    localparam int CLK_HZ      = 125_000_000;
    localparam int RATE_HZ     = 250;
    localparam int CONV_CYCLES = CLK_HZ / RATE_HZ;
    localparam int WORD_BITS   = 24;
    localparam int SHORT_BITS  = 16;
    localparam int CHANNELS    = 8;
    localparam int DAC_CHANS   = 4;
    localparam int DAC_BITS    = 14;
    localparam int DAC_FRAME   = 16;
    localparam int GAIN_LSB    = 18;
    localparam int WL_BIT      = 15;
    localparam int UNI_BIT     = 12;
    localparam logic [23:0] CFG_RESET = 24'h008000;
    localparam logic [23:0] MID_CODE  = 24'h800000;
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CONFIG = 8'h08;
    localparam logic [7:0] OFS_LINES  = 8'h0C;
    localparam logic [7:0] OFS_SAMPLE = 8'h20;
    localparam logic [7:0] OFS_DAC    = 8'h40;
    localparam logic       CTRL_RESET = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10
    } xfer_t;

    typedef struct packed {
        logic sclk;
        logic regSel;
        logic read_frame_sync_n;
        logic write_frame_sync_n;
        logic hostData;
    } adcPins_t;

    typedef struct packed {
        logic sclk;
        logic data;
        logic latch_n;
    } dacPins_t;

    typedef struct packed {
        logic [1:0] relayLvl;
        logic [1:0] relayDrv;
        logic [7:0] ledLvl;
        logic [7:0] ledDrv;
        logic       modeLvl;
        logic       modeDrv;
        logic       dirLvl;
        logic       dirDrv;
        logic       enLvl;
        logic       enDrv;
    } ctlPins_t;
endpackage

/* logic/analog_io_board_control.sv */
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module analog_io_board_control
    import aio_pkg::*;
#(
    parameter int CONV_P = CONV_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire adcPins_t    adcPins,
    input  wire logic [2:0]  chan_sel,
    output logic             adc_serial_out,
    input  wire dacPins_t    dacPins,
    input  wire ctlPins_t    ctlPins,
    output logic [DAC_CHANS-1:0][DAC_BITS-1:0] dacCode,
    output logic             dacOutOn,
    output logic [1:0]       relayOn,
    output logic [7:0]       ledOn,
    output logic             rs485Sel,
    output logic             txEnable,
    output logic             rxEnable
);
    localparam int CW = $clog2(CONV_P + 1);

    logic [23:0]   sample_r [CHANNELS];
    logic          convEn_r, convEn_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic          tick;
    logic [23:0]   result_r, result_nxt, code;
    logic          ready_r, ready_nxt;
    xfer_t         st_r, st_nxt;
    logic [23:0]   shift_r, shift_nxt, cfg_r, cfg_nxt;
    logic [4:0]    bits_r, bits_nxt, width;
    logic          sclkPrev_r, sdo_nxt;
    logic          rise, fall, startRd;
    logic [DAC_FRAME-1:0] dShift_r;
    logic          dClkPrev_r, dLatchPrev_r, dLoad;
    logic [10:0]   lines_nxt, lines_r;
    logic [31:0]   rdata;
    logic          hit;

    // Sample values stand for the analog inputs, one per channel
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < CHANNELS; i++) sample_r[i] <= 24'h000000;
            convEn_r <= CTRL_RESET;
        end else begin
            convEn_r <= convEn_nxt;
            if (psel && penable && pwrite && paddr[7:5] == OFS_SAMPLE[7:5])
                sample_r[paddr[4:2]] <= pwdata[23:0];
        end
    end

    // APB: no wait states; unmapped addresses answer with an error
    always_comb begin
        convEn_nxt = convEn_r;
        if (psel && penable && pwrite && paddr == OFS_CTRL)
            convEn_nxt = pwdata[0];
        hit   = 1'b1;
        rdata = 32'h00000000;
        if (paddr == OFS_CTRL)
            rdata = {31'h0, convEn_r};
        else if (paddr == OFS_STATUS)
            rdata = {24'h000000, 1'b0, chan_sel, st_r, 1'b0, ready_r};
        else if (paddr == OFS_CONFIG)
            rdata = {8'h00, cfg_r};
        else if (paddr == OFS_LINES)
            rdata = {20'h00000, dacOutOn, lines_r};
        else if (paddr[7:5] == OFS_SAMPLE[7:5])
            rdata = {8'h00, sample_r[paddr[4:2]]};
        else if (paddr[7:4] == OFS_DAC[7:4])
            rdata = {18'h0, dacCode[paddr[3:2]]};
        else
            hit = 1'b0;
    end
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata  = rdata;

    // Gain scaling and output coding of the selected channel
    always_comb begin
        logic signed [31:0] s;
        logic signed [31:0] u;
        s = 32'($signed(sample_r[chan_sel])) <<< cfg_r[GAIN_LSB +: 3];
        u = s <<< 1;
        code = 24'h000000;
        if (!cfg_r[UNI_BIT]) begin
            if (s > 32'sh007FFFFF)
                code = 24'h7FFFFF ^ MID_CODE;
            else if (s < -32'sh00800000)
                code = MID_CODE;
            else
                code = s[23:0] ^ MID_CODE;
        end else if (u > 32'sh00FFFFFF)
            code = 24'hFFFFFF;
        else if (u > 32'sh00000000)
            code = u[23:0];
    end

    // Conversion pacing; result taken from whichever channel is selected
    assign tick = convEn_r && cnt_r == CW'(CONV_P - 1);
    assign startRd = st_r == ST_IDLE && !adcPins.read_frame_sync_n;
    always_comb begin
        cnt_nxt    = convEn_r ? (tick ? '0 : cnt_r + 1'b1) : '0;
        result_nxt = tick ? code : result_r;
        ready_nxt  = ready_r;
        if (startRd && adcPins.regSel)
            ready_nxt = 1'b0;
        if (tick)
            ready_nxt = 1'b1;
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r    <= '0;
            result_r <= 24'h000000;
            ready_r  <= 1'b0;
        end else begin
            cnt_r    <= cnt_nxt;
            result_r <= result_nxt;
            ready_r  <= ready_nxt;
        end
    end

    // Serial transactions, framed by the host
    // No synchroniser on these pins: the host holds each level two cycles
    assign rise  = adcPins.sclk && !sclkPrev_r;
    assign fall  = !adcPins.sclk && sclkPrev_r;
    assign width = cfg_r[WL_BIT] ? 5'(WORD_BITS) : 5'(SHORT_BITS);
    always_comb begin
        st_nxt    = st_r;
        shift_nxt = shift_r;
        bits_nxt  = bits_r;
        cfg_nxt   = cfg_r;
        unique case (st_r)
            ST_IDLE: begin
                bits_nxt = 5'h00;
                if (!adcPins.read_frame_sync_n) begin
                    st_nxt    = ST_READ;
                    shift_nxt = adcPins.regSel ? result_r : cfg_r;
                end else if (!adcPins.write_frame_sync_n) begin
                    st_nxt = ST_WRITE;
                end
            end
            ST_READ: begin
                if (fall && bits_r < width) begin
                    shift_nxt = {shift_r[22:0], 1'b0};
                    bits_nxt  = bits_r + 5'h01;
                end
                if (adcPins.read_frame_sync_n)
                    st_nxt = ST_IDLE;
            end
            ST_WRITE: begin
                if (rise && bits_r < width) begin
                    shift_nxt = {shift_r[22:0], adcPins.hostData};
                    bits_nxt  = bits_r + 5'h01;
                    // Short words land in the top bits, low byte kept
                    if (bits_r == width - 5'h01 && !adcPins.regSel)
                        cfg_nxt = cfg_r[WL_BIT]
                            ? {shift_r[22:0], adcPins.hostData}
                            : {shift_r[14:0], adcPins.hostData,
                               cfg_r[7:0]};
                end
                if (adcPins.write_frame_sync_n)
                    st_nxt = ST_IDLE;
            end
            default: st_nxt = ST_IDLE;
        endcase
        sdo_nxt = st_nxt == ST_READ ? shift_nxt[23] : !ready_nxt;
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_r           <= ST_IDLE;
            shift_r        <= 24'h000000;
            bits_r         <= 5'h00;
            cfg_r          <= CFG_RESET;
            sclkPrev_r     <= 1'b0;
            adc_serial_out <= 1'b1;
        end else begin
            st_r           <= st_nxt;
            shift_r        <= shift_nxt;
            bits_r         <= bits_nxt;
            cfg_r          <= cfg_nxt;
            sclkPrev_r     <= adcPins.sclk;
            adc_serial_out <= sdo_nxt;
        end
    end

    // Output converter: two address bits then 14 data bits, MSB first
    assign dLoad = !dacPins.latch_n && dLatchPrev_r;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dShift_r     <= '0;
            dClkPrev_r   <= 1'b0;
            dLatchPrev_r <= 1'b1;
        end else begin
            dClkPrev_r   <= dacPins.sclk;
            dLatchPrev_r <= dacPins.latch_n;
            if (dacPins.sclk && !dClkPrev_r)
                dShift_r <= {dShift_r[DAC_FRAME-2:0], dacPins.data};
        end
    end
    for (genvar g = 0; g < DAC_CHANS; g++) begin : gDac
        logic [DAC_BITS-1:0] code_nxt;
        always_comb begin
            code_nxt = dacCode[g];
            if (dLoad && dShift_r[DAC_FRAME-1 -: 2] == 2'(g))
                code_nxt = dShift_r[DAC_BITS-1:0];
        end
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n)
                dacCode[g] <= '0;
            else
                dacCode[g] <= code_nxt;
        end
    end

    // Undriven lines count as inactive, as after power-up
    always_comb begin
        lines_nxt[1:0]  = ctlPins.relayDrv & ~ctlPins.relayLvl;
        lines_nxt[9:2]  = ctlPins.ledDrv & ~ctlPins.ledLvl;
        lines_nxt[10]   = ctlPins.modeDrv && ctlPins.modeLvl;
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lines_r  <= 11'h000;
            dacOutOn <= 1'b0;
            txEnable <= 1'b0;
            rxEnable <= 1'b0;
        end else begin
            lines_r  <= lines_nxt;
            dacOutOn <= ctlPins.enDrv && !ctlPins.enLvl;
            txEnable <= lines_nxt[10] && ctlPins.dirDrv
                        && ctlPins.dirLvl;
            rxEnable <= lines_nxt[10]
                        && !(ctlPins.dirDrv && ctlPins.dirLvl);
        end
    end
    assign relayOn  = lines_r[1:0];
    assign ledOn    = lines_r[9:2];
    assign rs485Sel = lines_r[10];

    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    ready_low_a: assert property (tick && st_r == ST_IDLE
        && adcPins.read_frame_sync_n |=> ##[0:1] !adc_serial_out)
        else $error("serial out not low after new result");
    read_src_a: assert property (startRd |=> shift_r ==
        (($past(adcPins.regSel)) ? $past(result_r) : $past(cfg_r)))
        else $error("read loaded wrong register");
    mid_code_a: assert property (tick && !cfg_r[UNI_BIT]
        && sample_r[chan_sel] == 24'h000000 |=> result_r == MID_CODE)
        else $error("zero input not mid code");
    gain_a: assert property (tick && !cfg_r[UNI_BIT]
        && cfg_r[GAIN_LSB +: 3] == 3'h7 && sample_r[chan_sel] == 24'h000001
        |=> result_r == 24'h800080)
        else $error("gain 128 scaling wrong");
    rate_a: assert property (tick |=> !tick [*8])
        else $error("results too close together");
    dac_en_a: assert property (!ctlPins.enDrv |=> !dacOutOn)
        else $error("outputs enabled while undriven");
    relay_a: assert property (ctlPins.relayDrv == 2'b00
        |=> relayOn == 2'b00)
        else $error("relay on while undriven");
    mode_a: assert property (!ctlPins.modeDrv |=> !rs485Sel
        && !txEnable)
        else $error("RS485 while mode undriven");
    dir_a: assert property (rs485Sel |-> txEnable != rxEnable)
        else $error("direction not exclusive");
    led_a: assert property (ctlPins.ledDrv == 8'hFF
        && ctlPins.ledLvl == 8'h00 |=> ledOn == 8'hFF)
        else $error("driven low LEDs dark");
    cfg_wr_a: assert property (st_r == ST_WRITE && rise
        && bits_r == width - 5'h01 && adcPins.regSel |=> cfg_r == $past(cfg_r))
        else $error("data write altered configuration");
    tx_idle_a: assert property (!rs485Sel |-> !txEnable && !rxEnable)
        else $error("direction active outside RS485");
    dac_load_a: assert property (dLoad
        && dShift_r[DAC_FRAME-1 -: 2] == 2'h3
        |=> dacCode[3] == $past(dShift_r[DAC_BITS-1:0]))
        else $error("output code not latched");
    read_len_a: assert property (st_r == ST_READ |-> bits_r <= width)
        else $error("read shifted past word width");
    idle_flag_a: assert property (st_r == ST_IDLE |-> adc_serial_out != ready_r)
        else $error("idle serial out not inverse of ready");
    dac_on_a: assert property (ctlPins.enDrv && !ctlPins.enLvl |=> dacOutOn)
        else $error("outputs not enabled while driven low");

    read_c:  cover property (startRd && adcPins.regSel);
    write_c: cover property (st_r == ST_WRITE && rise && bits_r == 5'h17);
    dac_c:   cover property (dLoad);
    uni_c:   cover property (tick && cfg_r[UNI_BIT]);
    short_c: cover property (st_r == ST_READ && fall && !cfg_r[WL_BIT]);
endmodule

/* dv/host_model.sv */
`timescale 1ns/1ps
module host_model
    import aio_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        adc_serial_out,
    output adcPins_t         adcPins,
    output dacPins_t         dacPins,
    output logic [23:0]      got,
    output logic             gotValid
);
    // Each level stands two cycles: the device has no pin synchroniser
    task automatic hold();
        repeat (2) @(posedge mclk);
    endtask

    initial begin
        adcPins  = 5'h0E;
        dacPins  = 3'h1;
        got      = 24'h000000;
        gotValid = 1'b0;
    end

    task automatic readWord(input logic sel, input int n, input logic keep);
        logic [23:0] w;
        w = 24'h000000;
        @(posedge mclk);
        adcPins.regSel <= sel;
        adcPins.read_frame_sync_n <= 1'b0;
        hold();
        for (int i = 0; i < n; i++) begin
            adcPins.sclk <= 1'b1;
            hold();
            w = {w[22:0], adc_serial_out};
            adcPins.sclk <= 1'b0;
            hold();
        end
        adcPins.read_frame_sync_n <= 1'b1;
        got <= w;
        gotValid <= keep;
        @(posedge mclk);
        gotValid <= 1'b0;
    endtask

    task automatic writeWord(input logic sel, input int n,
                             input logic [23:0] v);
        @(posedge mclk);
        adcPins.regSel <= sel;
        adcPins.write_frame_sync_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            adcPins.hostData <= v[i];
            hold();
            adcPins.sclk <= 1'b1;
            hold();
            adcPins.sclk <= 1'b0;
        end
        hold();
        adcPins.write_frame_sync_n <= 1'b1;
        // Released data line flips so a stale bit cannot pass for a live one
        adcPins.hostData <= ~v[0];
        hold();
    endtask

    task automatic dacLoad(input logic [15:0] f);
        @(posedge mclk);
        for (int i = 15; i >= 0; i--) begin
            dacPins.data <= f[i];
            hold();
            dacPins.sclk <= 1'b1;
            hold();
            dacPins.sclk <= 1'b0;
        end
        hold();
        dacPins.latch_n <= 1'b0;
        dacPins.data <= ~f[0];
        hold();
        dacPins.latch_n <= 1'b1;
        hold();
    endtask
endmodule

/* dv/tb.sv */
`timescale 1ns/1ps
module tb;
    import aio_pkg::*;
    localparam int CONV_T = 400;
    logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    adcPins_t    adcPins;
    dacPins_t    dacPins;
    ctlPins_t    ctlPins, c;
    logic [2:0]  chan_sel;
    logic        adc_serial_out, dacOutOn, rs485Sel, txEnable, rxEnable;
    logic        gotValid, mode, tx;
    logic [DAC_CHANS-1:0][DAC_BITS-1:0] dacCode;
    logic [1:0]  relayOn;
    logic [7:0]  ledOn;
    logic [23:0] got, v, w;
    logic [13:0] codes [4];
    logic [15:0] seed = 16'h3C63;
    logic [32:0] expQ [$];
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          t0;

    analog_io_board_control #(.CONV_P(CONV_T)) dut_u (
        .mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .adcPins, .chan_sel, .adc_serial_out, .dacPins,
        .ctlPins, .dacCode, .dacOutOn, .relayOn, .ledOn, .rs485Sel,
        .txEnable, .rxEnable);
    host_model hostU (.mclk, .adc_serial_out, .adcPins, .dacPins, .got,
        .gotValid);

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;

    function automatic logic [23:0] rnd24();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        rnd24[23:8] = seed;
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        rnd24[7:0] = seed[7:0];
    endfunction

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic giveUp();
        n_fail++;
        $display("[ERR] %0t wait ran out", $time);
        conclude();
    endtask

    // Reads only: a write has nothing to compare beyond its side effects
    always @(posedge mclk) begin
        if ((psel && penable && pready && !pwrite) || gotValid) begin
            if (expQ.size() == 0) begin
                n_fail++;
                $display("[ERR] %0t result with nothing expected", $time);
            end else if (gotValid) begin
                check({9'h000, got}, expQ.pop_front());
            end else begin
                check({pslverr, prdata}, expQ.pop_front());
            end
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) giveUp();
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        expQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic waitReady();
        int k;
        k = 0;
        repeat (2) @(posedge mclk);
        while (adc_serial_out !== 1'b0 && k < 3 * CONV_T) begin
            @(posedge mclk);
            k++;
        end
        if (adc_serial_out !== 1'b0) giveUp();
    endtask

    task automatic conv(input logic [2:0] ch, input logic [23:0] s,
                        input int n, input logic [23:0] e);
        apb(1'b1, OFS_SAMPLE + {3'h0, ch, 2'h0}, {8'h00, s});
        chan_sel <= ch;
        waitReady();
        hostU.readWord(1'b1, n, 1'b0);
        waitReady();
        t0 = cyc;
        expQ.push_back({9'h000, e});
        hostU.readWord(1'b1, n, 1'b1);
        repeat (2) @(posedge mclk);
        check({32'h0, adc_serial_out}, 33'h1);
        waitReady();
        check(33'(cyc - t0), 33'(CONV_T));
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        chan_sel = 3'h0;
        ctlPins  = '0;
        reset_n  = 1'b0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        rd(OFS_CTRL, 33'h0_0000_0001);
        rd(OFS_STATUS, 33'h0);
        rd(OFS_SAMPLE, 33'h0);
        rd(OFS_CONFIG, {9'h000, CFG_RESET});
        rd(OFS_LINES, 33'h0);
        rd(8'h10, 33'h1_0000_0000);
        apb(1'b1, OFS_CONFIG, 32'h0000_1234);
        rd(OFS_CONFIG, {9'h000, CFG_RESET});
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            v = rnd24();
            w = rnd24();
            ctlPins <= ctlPins_t'({v, w[1:0]});
            repeat (3) @(posedge mclk);
            c = ctlPins;
            mode = c.modeDrv & c.modeLvl;
            tx = mode & c.dirDrv & c.dirLvl;
            check({31'h0, txEnable, rxEnable}, {31'h0, tx, mode & ~tx});
            check({21'h0, dacOutOn, rs485Sel, ledOn, relayOn},
                {21'h0, c.enDrv & ~c.enLvl, mode, c.ledDrv & ~c.ledLvl,
                c.relayDrv & ~c.relayLvl});
            rd(OFS_LINES, {21'h0, c.enDrv & ~c.enLvl, mode,
                c.ledDrv & ~c.ledLvl, c.relayDrv & ~c.relayLvl});
        end
        $display("test lines done");
        conv(3'h0, 24'h7FFFFF, 24, 24'hFFFFFF);
        conv(3'h1, 24'h800000, 24, 24'h000000);
        conv(3'h2, 24'h000000, 24, MID_CODE);
        for (int i = 3; i < 8; i++) begin
            v = rnd24();
            conv(3'(i), v, 24, v ^ MID_CODE);
        end
        $display("test conversion done");
        hostU.writeWord(1'b0, 24, 24'h048000);
        rd(OFS_CONFIG, 33'h0_0004_8000);
        expQ.push_back(33'h0_0004_8000);
        hostU.readWord(1'b0, 24, 1'b1);
        conv(3'h5, 24'h100000, 24, 24'hA00000);
        conv(3'h6, 24'h500000, 24, 24'hFFFFFF);
        hostU.writeWord(1'b0, 24, 24'h040000);
        conv(3'h7, 24'h100000, 16, 24'h00A000);
        hostU.writeWord(1'b1, 16, 24'h00FFFF);
        rd(OFS_CONFIG, 33'h0_0004_0000);
        hostU.writeWord(1'b0, 16, 24'h001C80);
        rd(OFS_CONFIG, 33'h0_001C_8000);
        conv(3'h4, 24'h000001, 24, 24'h800080);
        hostU.writeWord(1'b0, 24, 24'h009000);
        conv(3'h3, 24'h200000, 24, 24'h400000);
        conv(3'h2, 24'hF00000, 24, 24'h000000);
        $display("test gain and width done");
        for (int j = 0; j < 4; j++) begin
            v = rnd24();
            codes[j] = v[13:0];
            hostU.dacLoad({2'(j), v[13:0]});
        end
        for (int j = 0; j < 4; j++) begin
            rd(OFS_DAC + {4'h0, 2'(j), 2'h0}, {19'h0, codes[j]});
            check({19'h0, dacCode[j]}, {19'h0, codes[j]});
        end
        repeat (2) @(posedge mclk);
        $display("test converter outputs done");
        conclude();
    end

    initial begin
        repeat (100000) @(posedge mclk);
        giveUp();
    end
endmodule
